// ---- src/fmtxc_top.sv ----
// Transmit multiplex configuration store with set/get command port.
// Assumes the controller holds cmd for one cycle and waits for cts.
// Functional notes
// - Enable property holds pilot, stereo, RDS enables; reset 0x0003.
// - Bit 2 gates RDS subcarrier; cleared at reset.
// - Bit 1 gates left-minus-right stereo; set at reset.
// - Bit 0 gates pilot tone; set at reset.
// - Clear-to-send rises once the next command is safe.
// - Audio deviation 16-bit, 10 Hz units, reset 6825.
// - Pilot deviation 16-bit, 10 Hz units, reset 675.
// - RDS deviation 16-bit, 10 Hz units, reset 200.
// - Line level bits 13:12 select attenuation range; reserved bits zero.
// - Line level bits 9:0 hold peak line amplitude in mV.
`timescale 1ns/1ps
`default_nettype none
module fmtxc_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        powered_up,
  input  wire logic [1:0]  cmd,
  input  wire logic [15:0] prop_num,
  input  wire logic [15:0] prop_wdata,
  output logic             cts,
  output logic             cmd_error,
  output logic [15:0]      prop_rdata,
  output logic             rdata_valid,
  output logic             pilot_enable,
  output logic             stereo_diff_enable,
  output logic             rds_enable,
  output logic [15:0]      audio_dev_value,
  output logic [15:0]      pilot_dev_value,
  output logic [15:0]      subcarrier_dev_value,
  output logic [1:0]       line_atten_select,
  output logic [9:0]       line_peak_level_mv
);
  typedef struct packed {
    fmtxc_pkg::fmtxc_state_t state;
    logic [1:0]              busy_cnt;
    logic                    err;
    logic [15:0]             rdata;
    logic                    rvalid;
  } fmtxc_top_st_t;

  fmtxc_top_st_t st_r;
  fmtxc_top_st_t st_nxt;
  fmtxc_prop_if  pif ();
  logic [2:0]    idx;
  logic          hit;
  logic [15:0]   wmask;

  fmtxc_store u_store (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pif     (pif)
  );

  // Property number to storage index
  always_comb begin
    hit   = 1'b1;
    idx   = 3'h0;
    wmask = 16'hFFFF;
    if (prop_num == fmtxc_pkg::PROP_ENABLES) begin
      idx   = 3'h0;
      wmask = fmtxc_pkg::MASK_ENABLES;
    end else if (prop_num == fmtxc_pkg::PROP_AUDIO_DEV) begin
      idx = 3'h1;
    end else if (prop_num == fmtxc_pkg::PROP_PILOT_DEV) begin
      idx = 3'h2;
    end else if (prop_num == fmtxc_pkg::PROP_RDS_DEV) begin
      idx = 3'h3;
    end else if (prop_num == fmtxc_pkg::PROP_LINE_LVL) begin
      idx   = 3'h4;
      wmask = fmtxc_pkg::MASK_LINE_LVL;
    end else begin
      hit = 1'b0;
    end
  end

  // Commands are taken only when idle; reserved bits forced to zero
  // so a careless host cannot leave junk that reads back later.
  assign pif.rd_idx  = idx;
  assign pif.wr_idx  = idx;
  assign pif.wr_data = prop_wdata & wmask;
  assign pif.wr_en   = (st_r.state == fmtxc_pkg::FMTXC_IDLE) &&
                       (cmd == fmtxc_pkg::CMD_SET) && hit && powered_up;

  // Sequencer: accept, go busy, then raise clear-to-send
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    case (st_r.state)
      fmtxc_pkg::FMTXC_IDLE: begin
        if (cmd != fmtxc_pkg::CMD_NONE) begin
          // Out-of-state or unknown access flagged, not stored
          st_nxt.err = !(powered_up && hit &&
                         ((cmd == fmtxc_pkg::CMD_SET) ||
                          (cmd == fmtxc_pkg::CMD_GET)));
          if (!st_nxt.err && (cmd == fmtxc_pkg::CMD_GET)) begin
            st_nxt.rdata  = pif.rd_data;
            st_nxt.rvalid = 1'b1;
          end
          st_nxt.busy_cnt = fmtxc_pkg::BUSY_CYCLES;
          st_nxt.state    = fmtxc_pkg::FMTXC_BUSY;
        end
      end
      fmtxc_pkg::FMTXC_BUSY: begin
        if (st_r.busy_cnt == 2'h1) begin
          st_nxt.state = fmtxc_pkg::FMTXC_IDLE;
        end
        st_nxt.busy_cnt = st_r.busy_cnt - 2'h1;
      end
      default: begin
        st_nxt.state = fmtxc_pkg::FMTXC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.state    <= fmtxc_pkg::FMTXC_IDLE;
      st_r.busy_cnt <= 2'h0;
      st_r.err      <= 1'b0;
      st_r.rdata    <= 16'h0000;
      st_r.rvalid   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cts         = (st_r.state == fmtxc_pkg::FMTXC_IDLE);
  assign cmd_error   = st_r.err;
  assign prop_rdata  = st_r.rdata;
  assign rdata_valid = st_r.rvalid;

  // Multiplex controls straight from stored registers
  assign rds_enable         = pif.enables[fmtxc_pkg::BIT_RDS];
  assign stereo_diff_enable = pif.enables[fmtxc_pkg::BIT_STEREO];
  assign pilot_enable       = pif.enables[fmtxc_pkg::BIT_PILOT];
  assign audio_dev_value      = pif.audio_dev;
  assign pilot_dev_value      = pif.pilot_dev;
  assign subcarrier_dev_value = pif.rds_dev;
  assign line_atten_select  =
    pif.line_lvl[fmtxc_pkg::ATTEN_LSB +: 2];
  assign line_peak_level_mv =
    pif.line_lvl[fmtxc_pkg::LEVEL_LSB +: 10];
endmodule : fmtxc_top
`default_nettype wire

// ---- src/fmtxc_pkg.sv ----
// Package for the transmit multiplex configuration store.
// Assumes property numbers arrive as 16-bit indices on the command port.
package fmtxc_pkg;
  // Property indices
  localparam logic [15:0] PROP_ENABLES   = 16'h2100;
  localparam logic [15:0] PROP_AUDIO_DEV = 16'h2101;
  localparam logic [15:0] PROP_PILOT_DEV = 16'h2102;
  localparam logic [15:0] PROP_RDS_DEV   = 16'h2103;
  localparam logic [15:0] PROP_LINE_LVL  = 16'h2104;
  // Reset values
  localparam logic [15:0] RST_ENABLES    = 16'h0003;
  localparam logic [15:0] RST_AUDIO_DEV  = 16'h1AA9;
  localparam logic [15:0] RST_PILOT_DEV  = 16'h02A3;
  localparam logic [15:0] RST_RDS_DEV    = 16'h00C8;
  localparam logic [15:0] RST_LINE_LVL   = 16'h327C;
  // Field positions and masks
  localparam int          BIT_PILOT      = 0;
  localparam int          BIT_STEREO     = 1;
  localparam int          BIT_RDS        = 2;
  localparam logic [15:0] MASK_ENABLES   = 16'h0007;
  localparam logic [15:0] MASK_LINE_LVL  = 16'h33FF;
  localparam int          ATTEN_LSB      = 12;
  localparam int          LEVEL_LSB      = 0;
  localparam int          NUM_PROPS      = 5;
  // Command codes
  localparam logic [1:0]  CMD_NONE       = 2'h0;
  localparam logic [1:0]  CMD_SET        = 2'h1;
  localparam logic [1:0]  CMD_GET        = 2'h2;
  // Cycles the store stays busy after a command
  localparam logic [1:0]  BUSY_CYCLES    = 2'h1;
  typedef enum logic [1:0] {
    FMTXC_IDLE,
    FMTXC_BUSY
  } fmtxc_state_t;
endpackage : fmtxc_pkg

// ---- src/fmtxc_prop_if.sv ----
// Interface between the command sequencer and the property storage.
// Assumes one clock domain; a write strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
interface fmtxc_prop_if;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [15:0] wr_data;
  logic [2:0]  rd_idx;
  logic [15:0] rd_data;
  logic [15:0] enables;
  logic [15:0] line_lvl;
  logic [15:0] audio_dev;
  logic [15:0] pilot_dev;
  logic [15:0] rds_dev;
  modport seq (output wr_en, output wr_idx, output wr_data, output rd_idx,
               input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx,
                 output rd_data, output enables, output line_lvl,
                 output audio_dev, output pilot_dev, output rds_dev);
endinterface : fmtxc_prop_if
`default_nettype wire

// ---- src/fmtxc_store.sv ----
// Property storage: five 16-bit registers with reset defaults.
// Assumes writes arrive already masked to their legal bits.
`timescale 1ns/1ps
`default_nettype none
module fmtxc_store (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  fmtxc_prop_if.store pif
);
  typedef struct packed {
    logic [fmtxc_pkg::NUM_PROPS-1:0][15:0] prop;
  } fmtxc_store_st_t;

  fmtxc_store_st_t st_r;
  fmtxc_store_st_t st_nxt;

  // Last written value wins per entry
  always_comb begin
    st_nxt = st_r;
    if (pif.wr_en && (pif.wr_idx < 3'(fmtxc_pkg::NUM_PROPS))) begin
      st_nxt.prop[pif.wr_idx] = pif.wr_data;
    end
  end

  // Constants only under reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.prop <= {fmtxc_pkg::RST_LINE_LVL, fmtxc_pkg::RST_RDS_DEV,
                    fmtxc_pkg::RST_PILOT_DEV, fmtxc_pkg::RST_AUDIO_DEV,
                    fmtxc_pkg::RST_ENABLES};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Out-of-range index reads zero
  assign pif.rd_data = (pif.rd_idx < 3'(fmtxc_pkg::NUM_PROPS)) ?
                       st_r.prop[pif.rd_idx] : 16'h0000;
  assign pif.enables   = st_r.prop[0];
  assign pif.audio_dev = st_r.prop[1];
  assign pif.pilot_dev = st_r.prop[2];
  assign pif.rds_dev   = st_r.prop[3];
  assign pif.line_lvl  = st_r.prop[4];
endmodule : fmtxc_store
`default_nettype wire

// ---- verification/fmtxc_monitor.sv ----
// Assertion checker for the transmit configuration store.
// Bound onto fmtxc_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module fmtxc_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        powered_up,
  input wire logic [1:0]  cmd,
  input wire logic [15:0] prop_num,
  input wire logic [15:0] prop_wdata,
  input wire logic        cts,
  input wire logic        cmd_error,
  input wire logic        rdata_valid,
  input wire logic        pilot_enable,
  input wire logic        stereo_diff_enable,
  input wire logic        rds_enable,
  input wire logic [15:0] audio_dev_value,
  input wire logic [1:0]  line_atten_select,
  input wire logic [9:0]  line_peak_level_mv
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Accepted request, and accepted set of one property
  sequence s_req;
    cts && cmd != 2'h0;
  endsequence
  sequence s_set(p);
    s_req ##0 cmd == 2'h1 && powered_up && prop_num == p;
  endsequence
  chk_cts_busy: assert property (s_req |=> !cts ##1 cts)
    else $error("cts did not drop for one cycle");
  chk_en_set: assert property (s_set(16'h2100) |=>
    {rds_enable, stereo_diff_enable, pilot_enable} == $past(prop_wdata[2:0]))
    else $error("enable outputs wrong after set");
  chk_en_hold: assert property (!(cts && cmd == 2'h1 && powered_up &&
    prop_num == 16'h2100) |=>
    $stable({rds_enable, stereo_diff_enable, pilot_enable}))
    else $error("enable outputs changed without set");
  chk_audio_set: assert property (s_set(16'h2101) |=>
    audio_dev_value == $past(prop_wdata)) else $error("audio value wrong");
  chk_line_set: assert property (s_set(16'h2104) |=>
    {line_atten_select, line_peak_level_mv} == {$past(prop_wdata[13:12]),
    $past(prop_wdata[9:0])}) else $error("line fields wrong");
  chk_get_ack: assert property (s_req ##0 cmd == 2'h2 && powered_up &&
    prop_num inside {[16'h2100:16'h2104]} |=> rdata_valid && !cmd_error)
    else $error("read not answered");
  chk_off_refuse: assert property (s_req ##0 !powered_up |=>
    cmd_error && !rdata_valid) else $error("powered-down access taken");
endmodule : fmtxc_monitor
bind fmtxc_top fmtxc_monitor u_mon (.clk_sys, .sys_rst, .powered_up, .cmd,
  .prop_num, .prop_wdata, .cts, .cmd_error, .rdata_valid, .pilot_enable,
  .stereo_diff_enable, .rds_enable, .audio_dev_value, .line_atten_select,
  .line_peak_level_mv);
`default_nettype wire

// ---- verification/fmtxc_host.sv ----
// Controller model issuing property set and get commands.
// Drives at the falling edge; waits for cts before each request.
`timescale 1ns/1ps
`default_nettype none
module fmtxc_host (
  input  wire logic        clk_sys,
  input  wire logic        cts,
  output logic [1:0]       cmd,
  output logic [15:0]      prop_num,
  output logic [15:0]      prop_wdata
);
  initial {cmd, prop_num, prop_wdata} = 34'h0;
  // One-cycle request; qualifiers inverted after, so stale data never helps
  task automatic xfer(input logic [1:0] c, input logic [15:0] p,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cts !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    cmd = c;
    prop_num = p;
    prop_wdata = d;
    @(negedge clk_sys);
    cmd = 2'h0;
    prop_num = ~p;
    prop_wdata = ~d;
  endtask : xfer
endmodule : fmtxc_host
`default_nettype wire

// ---- verification/fm_tx_component_config_tb.sv ----
// Self-checking bench for the transmit configuration store.
// Drives through the controller model; reads checked at falling edges.
`timescale 1ns/1ps
`default_nettype none
module fm_tx_component_config_tb;
  logic        clk_sys, sys_rst, powered_up, cts, cmd_error, rdata_valid;
  logic        pilot_enable, stereo_diff_enable, rds_enable;
  logic [1:0]  cmd, line_atten_select;
  logic [15:0] prop_num, prop_wdata, prop_rdata, d, exp_q[$];
  logic [15:0] audio_dev_value, pilot_dev_value, subcarrier_dev_value;
  logic [9:0]  line_peak_level_mv;
  logic [16:0] seed;
  int          mismatches, checked, cycles;
  fmtxc_top DUT (.clk_sys, .sys_rst, .powered_up, .cmd, .prop_num,
    .prop_wdata, .cts, .cmd_error, .prop_rdata, .rdata_valid, .pilot_enable,
    .stereo_diff_enable, .rds_enable, .audio_dev_value, .pilot_dev_value,
    .subcarrier_dev_value, .line_atten_select, .line_peak_level_mv);
  fmtxc_host u_host (.clk_sys, .cts, .cmd, .prop_num, .prop_wdata);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // Note the expected word first, then issue the read
  task automatic get(input logic [15:0] p, e);
    exp_q.push_back(e);
    u_host.xfer(2'h2, p, 16'h0000);
  endtask : get
  task automatic complete_run;
    $display("Counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Read watcher: pulse is one cycle wide, so look at every falling edge
  always @(negedge clk_sys) begin
    if (rdata_valid === 1'b1 && exp_q.size() > 0) begin
      check("read data", exp_q.pop_front(), prop_rdata);
    end
  end
  // Hang guard, well above the roughly 85 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {sys_rst, powered_up, seed} = {2'h3, 17'h15B68};
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    check("enables", 16'h0003, {13'h0000, rds_enable, stereo_diff_enable,
      pilot_enable});
    get(16'h2101, 16'h1AA9);
    get(16'h2102, 16'h02A3);
    get(16'h2103, 16'h00C8);
    get(16'h2104, 16'h327C);
    $display("Test reset values done");
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(2'h1, 16'h2100, 16'(i));
      check("enables", 16'(i), {13'h0000, rds_enable, stereo_diff_enable,
        pilot_enable});
      get(16'h2100, 16'(i));
    end
    for (int i = 1; i < 4; i++) begin
      seed = lfsr(seed);
      d = {5'h00, seed[10:0]};
      u_host.xfer(2'h1, 16'h2100 + 16'(i), d);
      check("deviation", d, i == 1 ? audio_dev_value : i == 2 ?
        pilot_dev_value : subcarrier_dev_value);
      get(16'h2100 + 16'(i), d);
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = {2'h0, 2'(i), 2'h0, seed[9:0]};
      u_host.xfer(2'h1, 16'h2104, d);
      check("line", d, {2'h0, line_atten_select, 2'h0,
        line_peak_level_mv});
      get(16'h2104, d);
    end
    $display("Test writes and reads done");
    powered_up = 1'b0;
    u_host.xfer(2'h2, 16'h2100, 16'h0000);
    check("refused", 16'h0001, {15'h0000, cmd_error});
    powered_up = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("pending reads", 16'h0000, 16'(exp_q.size()));
    u_host.xfer(2'h3, 16'h2100, 16'h0000);
    check("bad code", 16'h0001, {15'h0000, cmd_error});
    u_host.xfer(2'h1, 16'h2105, 16'h0005);
    check("bad prop", 16'h0001, {15'h0000, cmd_error});
    check("enables kept", 16'h0007, {13'h0000, rds_enable,
      stereo_diff_enable, pilot_enable});
    get(16'h2100, 16'h0007);
    check("good cmd", 16'h0000, {15'h0000, cmd_error});
    $display("Test powered-down refusal done");
    complete_run();
  end
endmodule : fm_tx_component_config_tb
`default_nettype wire
